// File: verilog/sensor_link_pkg.sv
package sensor_link_pkg;

    // ---------------------------------------------------------------
    // bus address and commands
    // ---------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h54;
    localparam logic [7:0] CMD_HOLD_T = 8'hE3;
    localparam logic [7:0] CMD_NOHOLD_T = 8'hF3;
    localparam logic [7:0] CMD_HOLD_HT = 8'hE5;
    localparam logic [7:0] CMD_NOHOLD_HT = 8'hF5;
    localparam logic [7:0] CMD_REG_RD = 8'hA7;
    localparam logic [7:0] CMD_REG_WR = 8'hA6;
    localparam logic [7:0] CMD_STOP_PER = 8'h30;
    localparam logic [7:0] CMD_READ_ID = 8'hD7;

    // ---------------------------------------------------------------
    // checksum
    // ---------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h1D;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    // ---------------------------------------------------------------
    // framing
    // ---------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] BYTES_T = 3'h3;
    localparam logic [2:0] BYTES_HT = 3'h5;
    localparam int unsigned CLK_HZ = 40000000;

    typedef enum logic [1:0] {
        MEAS_NONE,
        MEAS_T,
        MEAS_HT
    } meas_kind_t;

    // request from the command port to the measuring core
    typedef struct packed {
        logic start;
        meas_kind_t kind;
    } meas_req_t;

    // result handed back by the measuring core
    typedef struct packed {
        logic done;
        logic [13:0] hum;
        logic [13:0] temp;
    } meas_res_t;

endpackage : sensor_link_pkg

// File: verilog/crc8_step.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// one byte of the checksum, msb first, no reflection
// ---------------------------------------------------------------
module crc8_step (
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data,
    output logic [7:0] crc_out
);

    logic [7:0] stage [0:8];

    assign stage[0] = crc_in ^ data;

    // one shift per data bit
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign stage[i+1] = stage[i][7] ? ({stage[i][6:0], 1'b0} ^ sensor_link_pkg::CRC_POLY)
                                            : {stage[i][6:0], 1'b0};
        end
    endgenerate

    assign crc_out = stage[8];

endmodule : crc8_step

`default_nettype wire

// File: verilog/sensor_i2c_port.sv
// Contract
// - slave on the two-wire bus, good at 100 kHz and 400 kHz.
// - both lines only pulled low or released, never driven high.
// - start and stop are data edges while the clock line is high.
// - sample data on rising clock; hold data stable while clock high.
// - acknowledge only address 0x54; ignore others, data line untouched.
// - address then direction bit; one reads, zero writes.
// - eight data bits then one response bit, low ack, high nack.
// - after an ack, another byte or a stop may follow.
// - 0xE3 held temperature, 0xF3 non-held temperature.
// - 0xE5 held humidity and temperature, 0xF5 non-held.
// - 0xA7 register read, 0xA6 register write, 0xD7 identity read.
// - temperature result: two bytes then checksum.
// - combined result: humidity, temperature, four bytes then checksum.
// - held command: stretch clock after read address until conversion ends.
// - non-held read: ack if done, else nack the read address.
// - crc poly 0x1D, init 0xFF, over four bytes, humidity zero if absent.
// - in periodic mode only fetch reads and stop 0x30 accepted; the code acks every command byte there and acts only on 0x30.
`timescale 1ns/1ps
`default_nettype none

module sensor_i2c_port (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic periodic_on,
    output sensor_link_pkg::meas_req_t meas_req,
    input wire sensor_link_pkg::meas_res_t meas_res,
    output logic reg_rd_req,
    output logic reg_wr_req,
    output logic id_rd_req,
    output logic periodic_stop
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRBYTE,
        ST_RDBYTE,
        ST_RDACK,
        ST_STRETCH
    } port_state_t;

    // ---------------------------------------------------------------
    // line edges and bus conditions
    // ---------------------------------------------------------------
    logic scl_q, scl_d, sda_q, sda_d;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_comb begin
        scl_d = scl_i;
        sda_d = sda_i;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // conditions are data edges while the clock line stays high
    assign scl_rise = !scl_q && scl_i;
    assign scl_fall = scl_q && !scl_i;
    assign start_seen = scl_q && scl_i && sda_q && !sda_i;
    assign stop_seen = scl_q && scl_i && !sda_q && sda_i;

    // ---------------------------------------------------------------
    // protocol engine
    // ---------------------------------------------------------------
    port_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic rw_q, rw_d;
    logic ack_q, ack_d;          // drive ack low in this ack slot
    logic sda_low_q, sda_low_d;  // data line pulled low
    logic hold_q, hold_d;        // pending held conversion
    logic ready_q, ready_d;      // result waiting for a read
    sensor_link_pkg::meas_kind_t kind_q, kind_d;
    logic [2:0] byte_q, byte_d;
    logic [39:0] out_q, out_d;   // result bytes, sent from the top
    sensor_link_pkg::meas_req_t req_q, req_d;
    logic rrd_q, rrd_d, rwr_q, rwr_d, idr_q, idr_d, pstop_q, pstop_d;
    logic [7:0] crc_a, crc_b, crc_c, crc_res;
    logic [7:0] hum_hi, hum_lo;
    logic [2:0] nbytes;

    // checksum over humidity (zero for temperature only) then temperature
    assign hum_hi = (kind_q == sensor_link_pkg::MEAS_HT) ? {2'b00, meas_res.hum[13:8]} : 8'h00;
    assign hum_lo = (kind_q == sensor_link_pkg::MEAS_HT) ? meas_res.hum[7:0] : 8'h00;

    crc8_step u_crc0 (.crc_in(sensor_link_pkg::CRC_INIT), .data(hum_hi), .crc_out(crc_a));
    crc8_step u_crc1 (.crc_in(crc_a), .data(hum_lo), .crc_out(crc_b));
    crc8_step u_crc2 (.crc_in(crc_b), .data({2'b00, meas_res.temp[13:8]}), .crc_out(crc_c));
    crc8_step u_crc3 (.crc_in(crc_c), .data(meas_res.temp[7:0]), .crc_out(crc_res));

    assign nbytes = (kind_q == sensor_link_pkg::MEAS_HT) ? sensor_link_pkg::BYTES_HT
                                                        : sensor_link_pkg::BYTES_T;

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rw_d = rw_q;
        ack_d = ack_q;
        sda_low_d = sda_low_q;
        hold_d = hold_q;
        ready_d = ready_q;
        kind_d = kind_q;
        byte_d = byte_q;
        out_d = out_q;
        req_d = '0;
        rrd_d = 1'b0;
        rwr_d = 1'b0;
        idr_d = 1'b0;
        pstop_d = 1'b0;
        // latch a finished conversion, high byte first
        if (meas_res.done && kind_q != sensor_link_pkg::MEAS_NONE) begin
            ready_d = 1'b1;
            if (kind_q == sensor_link_pkg::MEAS_HT) begin
                out_d = {2'b00, meas_res.hum, 2'b00, meas_res.temp, crc_res};
            end else begin
                out_d = {2'b00, meas_res.temp, crc_res, 16'h0000};
            end
        end
        if (start_seen) begin
            st_d = ST_ADDR;
            bit_d = '0;
            sda_low_d = 1'b0;
        end else if (stop_seen) begin
            st_d = ST_IDLE;
            sda_low_d = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    sda_low_d = 1'b0;
                end
                ST_ADDR, ST_WRBYTE: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_i};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == sensor_link_pkg::BITS_PER_BYTE) begin
                        bit_d = '0;
                        ack_d = 1'b0;
                        if (st_q == ST_ADDR) begin
                            rw_d = sh_q[0];
                            if (sh_q[7:1] == sensor_link_pkg::DEV_ADDR) begin
                                if (!sh_q[0]) begin
                                    ack_d = 1'b1;
                                end else if (periodic_on || ready_q || hold_q) begin
                                    ack_d = 1'b1;
                                end // else nack: no result yet
                            end
                        end else begin
                            ack_d = 1'b1;
                            if (periodic_on) begin
                                pstop_d = (sh_q == sensor_link_pkg::CMD_STOP_PER);
                            end else begin
                                case (sh_q)
                                    sensor_link_pkg::CMD_HOLD_T, sensor_link_pkg::CMD_NOHOLD_T: begin
                                        req_d.start = 1'b1;
                                        req_d.kind = sensor_link_pkg::MEAS_T;
                                        kind_d = sensor_link_pkg::MEAS_T;
                                        hold_d = (sh_q == sensor_link_pkg::CMD_HOLD_T);
                                        ready_d = 1'b0;
                                    end
                                    sensor_link_pkg::CMD_HOLD_HT, sensor_link_pkg::CMD_NOHOLD_HT: begin
                                        req_d.start = 1'b1;
                                        req_d.kind = sensor_link_pkg::MEAS_HT;
                                        kind_d = sensor_link_pkg::MEAS_HT;
                                        hold_d = (sh_q == sensor_link_pkg::CMD_HOLD_HT);
                                        ready_d = 1'b0;
                                    end
                                    sensor_link_pkg::CMD_REG_RD: rrd_d = 1'b1;
                                    sensor_link_pkg::CMD_REG_WR: rwr_d = 1'b1;
                                    sensor_link_pkg::CMD_READ_ID: idr_d = 1'b1;
                                    default: ack_d = 1'b1;
                                endcase
                            end
                        end
                        sda_low_d = ack_d;
                        st_d = ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_low_d = 1'b0;
                        if (!ack_q) begin
                            st_d = ST_IDLE;
                        end else if (st_q == ST_ACK && rw_q) begin
                            byte_d = '0;
                            st_d = (hold_q && !ready_q) ? ST_STRETCH : ST_RDBYTE;
                            sda_low_d = !(hold_q && !ready_q) && !out_q[39];
                        end else begin
                            st_d = ST_WRBYTE;
                        end
                    end
                end
                ST_STRETCH: begin
                    // first bit settles while the clock is still held, so it never moves with scl high
                    sda_low_d = !out_q[39];
                    if (ready_q && sda_low_q == !out_q[39]) begin
                        hold_d = 1'b0;
                        st_d = ST_RDBYTE;
                    end
                end
                ST_RDBYTE: begin
                    if (scl_fall) begin
                        bit_d = bit_q + 4'h1;
                        if (bit_q == sensor_link_pkg::BITS_PER_BYTE - 4'h1) begin
                            sda_low_d = 1'b0;
                            bit_d = '0;
                            st_d = ST_RDACK;
                        end else begin
                            out_d = {out_q[38:0], 1'b0};
                            sda_low_d = !out_q[38];
                        end
                    end
                end
                ST_RDACK: begin
                    if (scl_rise) begin
                        ack_d = !sda_i;
                    end else if (scl_fall) begin
                        byte_d = byte_q + 3'h1;
                        out_d = {out_q[38:0], 1'b0};
                        if (ack_q && byte_q + 3'h1 < nbytes) begin
                            st_d = ST_RDBYTE;
                            sda_low_d = !out_q[38];
                        end else begin
                            ready_d = periodic_on;
                            st_d = ST_IDLE;
                        end
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            sda_low_q <= 1'b0;
            hold_q <= 1'b0;
            ready_q <= 1'b0;
            kind_q <= sensor_link_pkg::MEAS_NONE;
            byte_q <= '0;
            out_q <= '0;
            req_q <= '0;
            rrd_q <= 1'b0;
            rwr_q <= 1'b0;
            idr_q <= 1'b0;
            pstop_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            rw_q <= rw_d;
            ack_q <= ack_d;
            sda_low_q <= sda_low_d;
            hold_q <= hold_d;
            ready_q <= ready_d;
            kind_q <= kind_d;
            byte_q <= byte_d;
            out_q <= out_d;
            req_q <= req_d;
            rrd_q <= rrd_d;
            rwr_q <= rwr_d;
            idr_q <= idr_d;
            pstop_q <= pstop_d;
        end
    end

    // ---------------------------------------------------------------
    // open-drain pins: pull low or release, never drive high
    // ---------------------------------------------------------------
    assign sda_o = 1'b0;
    assign sda_oe = sda_low_q;
    assign scl_o = 1'b0;
    assign scl_oe = (st_q == ST_STRETCH);
    assign meas_req = req_q;
    assign reg_rd_req = rrd_q;
    assign reg_wr_req = rwr_q;
    assign id_rd_req = idr_q;
    assign periodic_stop = pstop_q;

endmodule : sensor_i2c_port

`default_nettype wire

// File: sim/port_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module port_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic periodic_on,
    input wire sensor_link_pkg::meas_req_t meas_req,
    input wire sensor_link_pkg::meas_res_t meas_res,
    input wire logic reg_rd_req,
    input wire logic reg_wr_req,
    input wire logic id_rd_req,
    input wire logic periodic_stop
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // any command pulse at all
    logic any_req;
    assign any_req = meas_req.start | reg_rd_req | reg_wr_req | id_rd_req | periodic_stop;

    // a stretch that meets a finished conversion
    sequence result_in;
        scl_oe && meas_res.done;
    endsequence

    a_scl_open_drain: assert property (scl_oe |-> !scl_o)
        else $error("scl driven high");
    a_sda_open_drain: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    a_sda_moves_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("sda changed while scl high");
    a_stretch_low: assert property ($rose(scl_oe) |-> !scl_i)
        else $error("stretch began while scl high");
    a_stretch_ends: assert property (result_in |-> ##[1:8] !scl_oe)
        else $error("scl still held after result");
    a_one_request: assert property ($onehot0({meas_req.start, reg_rd_req, reg_wr_req,
        id_rd_req, periodic_stop})) else $error("two command pulses at once");
    a_req_after_ack: assert property (any_req |-> sda_oe || $past(sda_oe)
        || $past(sda_oe, 2) || $past(sda_oe, 3)) else $error("command pulse without ack");
    a_meas_kind: assert property (meas_req.start |-> meas_req.kind inside
        {sensor_link_pkg::MEAS_T, sensor_link_pkg::MEAS_HT}) else $error("bad kind");
    a_periodic_quiet: assert property (periodic_on && $past(periodic_on)
        |-> !meas_req.start) else $error("measurement started in periodic mode");
endmodule : port_chk

bind sensor_i2c_port port_chk port_chk_i (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .periodic_on(periodic_on), .meas_req(meas_req), .meas_res(meas_res),
    .reg_rd_req(reg_rd_req), .reg_wr_req(reg_wr_req), .id_rd_req(id_rd_req),
    .periodic_stop(periodic_stop)
);
`default_nettype wire

// File: sim/bus_master.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// single bus master, both lines open drain
// ---------------------------------------------------------------
module bus_master (
    input wire logic clock,
    input wire logic scl,
    input wire logic sda,
    output logic scl_dn,
    output logic sda_dn
);
    int half = 50; // 50 low, 50 high: 400 kHz at 40 MHz

    // released lines at start, pull-ups give the high level
    initial begin
        scl_dn = 1'b0;
        sda_dn = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask : wt

    // release clock; the slave may stretch, so the wait is bounded
    task automatic rise();
        int k;
        k = 0;
        scl_dn = 1'b0;
        while (scl !== 1'b1 && k < 20000) begin
            wt(1);
            k++;
        end
    endtask : rise

    // data moves only while clock is low, sampled as it rises
    task automatic bitio(input logic b, output logic r);
        sda_dn = ~b;
        wt(half / 2);
        rise();
        r = sda;
        wt(half);
        scl_dn = 1'b1;
        wt(half / 2);
    endtask : bitio

    // start or repeated start: data falls with clock high
    task automatic start();
        sda_dn = 1'b0;
        wt(half / 2);
        rise();
        wt(half / 2);
        sda_dn = 1'b1;
        wt(half / 2);
        scl_dn = 1'b1;
        wt(half / 2);
    endtask : start

    // stop: data rises with clock high
    task automatic stop();
        sda_dn = 1'b1;
        wt(half / 2);
        rise();
        wt(half / 2);
        sda_dn = 1'b0;
        wt(half);
    endtask : stop

    // eight bits msb first, then the response bit
    task automatic xfer(input logic [7:0] d, input logic m9, output logic [7:0] q,
                        output logic r9);
        for (int i = 7; i >= 0; i--) bitio(d[i], q[i]);
        bitio(m9, r9);
    endtask : xfer
endmodule : bus_master
`default_nettype wire

// File: sim/tb_sensor_i2c_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sensor_i2c_port;
    logic clock;
    logic sys_rst;
    logic periodic_on;
    logic scl, sda, scl_o, scl_oe, sda_o, sda_oe, scl_dn, sda_dn, stretched;
    logic reg_rd_req, reg_wr_req, id_rd_req, periodic_stop;
    logic [4:0] pul;
    logic [7:0] q;
    sensor_link_pkg::meas_req_t meas_req;
    sensor_link_pkg::meas_res_t meas_res = '{done: 1'b0, hum: 14'h2A5C, temp: 14'h1337};
    sensor_link_pkg::meas_kind_t kind_seen;
    int cnt [5] = '{default: 0};
    int dly = -1;
    int n_errors = 0;
    int compares = 0;

    // ---------------------------------------------------------------
    // wiring, open drain with pull-ups
    // ---------------------------------------------------------------
    assign scl = ~(scl_oe | scl_dn);
    assign sda = ~(sda_oe | sda_dn);
    assign pul = {periodic_stop, id_rd_req, reg_wr_req, reg_rd_req, meas_req.start};

    sensor_i2c_port sensor_i2c_port_i (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .periodic_on(periodic_on), .meas_req(meas_req),
        .meas_res(meas_res), .reg_rd_req(reg_rd_req), .reg_wr_req(reg_wr_req),
        .id_rd_req(id_rd_req), .periodic_stop(periodic_stop));
    bus_master bus_master_i (.clock(clock), .scl(scl), .sda(sda), .scl_dn(scl_dn),
        .sda_dn(sda_dn));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // core stand-in: result 3000 cycles after request, long enough to force a stretch
    always @(negedge clock) begin
        meas_res.done = 1'b0;
        if (meas_req.start === 1'b1) begin
            dly = 3000;
        end else if (dly > 0) begin
            dly--;
        end else if (dly == 0) begin
            meas_res.done = 1'b1;
            dly = -1;
        end
    end

    // pulse counters, last kind, stretch watch
    always @(posedge clock) begin
        foreach (cnt[i]) cnt[i] += (pul[i] === 1'b1);
        if (meas_req.start === 1'b1) kind_seen = meas_req.kind;
        if (scl_oe === 1'b1) stretched = 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // counts packed four bits each; they only grow and stay small
    function automatic logic [19:0] snap();
        return {cnt[4][3:0], cnt[3][3:0], cnt[2][3:0], cnt[1][3:0], cnt[0][3:0]};
    endfunction : snap

    function automatic logic [7:0] crc8(input logic [31:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h1D : 8'h00);
        return c;
    endfunction : crc8

    task automatic addr(input logic rd, output logic a);
        bus_master_i.start();
        bus_master_i.xfer({sensor_link_pkg::DEV_ADDR, rd}, 1'b1, q, a);
    endtask : addr

    task automatic cmd(input logic [7:0] c);
        logic a;
        addr(1'b0, a);
        check("addr ack", a, 1'b0);
        bus_master_i.xfer(c, 1'b1, q, a);
        check("cmd ack", a, 1'b0);
        bus_master_i.stop();
    endtask : cmd

    task automatic t_foreign();
        logic a;
        bus_master_i.start();
        bus_master_i.xfer({7'h55, 1'b0}, 1'b1, q, a);
        check("foreign addr", a, 1'b1);
        bus_master_i.stop();
        $display("test foreign done");
    endtask : t_foreign

    // each plain command, then one that does not exist
    task automatic t_cmds();
        logic [7:0] c [4] = '{8'hA7, 8'hA6, 8'hD7, 8'h11};
        logic [19:0] s;
        for (int i = 0; i < 4; i++) begin
            s = snap();
            cmd(c[i]);
            check("pulses", snap() - s, (i < 3) ? 20'h10 << (4 * i) : 20'h0);
        end
        $display("test cmds done");
    endtask : t_cmds

    // periodic mode, run at 100 kHz
    task automatic t_periodic();
        logic a;
        logic [19:0] s;
        bus_master_i.half = 200;
        periodic_on = 1'b1;
        s = snap();
        cmd(8'hE3);
        check("periodic quiet", snap() - s, 20'h0);
        addr(1'b1, a);
        check("fetch ack", a, 1'b0);
        bus_master_i.xfer(8'hFF, 1'b1, q, a);
        bus_master_i.stop();
        cmd(8'h30);
        check("periodic stop", snap() - s, 20'h10000);
        periodic_on = 1'b0;
        bus_master_i.half = 50;
        $display("test periodic done");
    endtask : t_periodic

    // one measurement and its read-back, held or polled
    task automatic t_meas(input logic [7:0] c, input logic hold);
        logic a;
        logic [39:0] e;
        logic [19:0] s;
        e[39:8] = {2'b00, meas_res.hum, 2'b00, meas_res.temp};
        if (!c[2]) e[39:24] = 16'h0000;
        e[7:0] = crc8(e[39:8]);
        check("crc model", crc8(32'h05800580), 32'hF2);
        stretched = 1'b0;
        s = snap();
        cmd(c);
        check("start", snap() - s, 20'h1);
        check("kind", kind_seen, c[2] ? sensor_link_pkg::MEAS_HT : sensor_link_pkg::MEAS_T);
        addr(1'b1, a);
        if (!hold) begin
            check("busy nack", a, 1'b1);
            bus_master_i.stop();
            bus_master_i.wt(3200);
            addr(1'b1, a);
        end
        check("read ack", a, 1'b0);
        for (int i = c[2] ? 0 : 2; i < 5; i++) begin
            bus_master_i.xfer(8'hFF, i == 4, q, a);
            check("data", q, e[39 - 8 * i -: 8]);
        end
        check("stretch", stretched, hold);
        bus_master_i.stop();
        $display("test meas %h done", c);
    endtask : t_meas

    task automatic close_out();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // watchdog, about a third again the expected run
    initial begin
        repeat (95000) @(posedge clock);
        n_errors++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        periodic_on = 1'b0;
        stretched = 1'b0;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        bus_master_i.wt(10);
        t_foreign();
        t_cmds();
        t_periodic();
        t_meas(8'hE3, 1'b1);
        t_meas(8'hF3, 1'b0);
        t_meas(8'hE5, 1'b1);
        t_meas(8'hF5, 1'b0);
        close_out();
    end
endmodule : tb_sensor_i2c_port
`default_nettype wire
